/* File: core/uaps_consts.vh */
// constants and operating summary for the audio playback sequencer
// Summary of operation
// - ready for setup only after reset sequence done and bus attached; then accept audio.
// - idle holds both outputs at mid-scale and zero indicator high.
// - first arriving packet (1 ms of samples) is buffered before output starts.
// - after first packet buffered, playout starts at a start-of-frame token.
// - on stream end, keep playing until the last received data is played, then stop.
// - playback indicator low while audio is playing.
// - suspend indicator low while bus suspend is detected.
// - zero indicator high after 1024 consecutive all-zero samples.
// - about 350 us of initialisation after power-on reset before sequence is done.
`ifndef UAPS_CONSTS_VH
`define UAPS_CONSTS_VH
`define UAPS_CLK_HZ        10000000
`define UAPS_INIT_NS       350000
`define UAPS_INIT_CYC      ((`UAPS_INIT_NS * (`UAPS_CLK_HZ / 1000000) + 999) / 1000)
`define UAPS_ZERO_RUN      11'h400
`define UAPS_PKT_SAMPLES   6'h30
`define UAPS_BUF_DEPTH     64
`define UAPS_MIDSCALE      16'h0000
`define UAPS_ST_INIT       3'h0
`define UAPS_ST_DETACHED   3'h1
`define UAPS_ST_IDLE       3'h2
`define UAPS_ST_BUFFER     3'h3
`define UAPS_ST_WAIT_SOF   3'h4
`define UAPS_ST_PLAY       3'h5
`endif

/* File: core/uaps_sequencer.v */
// playback sequencer with status indicators and one-packet sample buffer
`timescale 1ns/100ps
`default_nettype none
`include "uaps_consts.vh"
module uaps_sequencer #(
  parameter INIT_CYCLES = `UAPS_INIT_CYC
) (
  input  wire        clk_sys_in,
  input  wire        rst_in,
  input  wire        bus_attached_in,
  input  wire        bus_suspend_in,
  input  wire        sof_in,
  input  wire        stream_active_in,
  input  wire        sample_valid_in,
  input  wire [15:0] sample_left_in,
  input  wire [15:0] sample_right_in,
  input  wire        sample_tick_in,
  output wire        setup_ready_out,
  output wire        sample_ready_out,
  output wire [15:0] dac_left_out,
  output wire [15:0] dac_right_out,
  output wire        playing_indicator_n_out,
  output wire        bus_sleep_indicator_n_out,
  output wire        zero_indicator_out
);
  localparam ST_INIT     = `UAPS_ST_INIT;
  localparam ST_DETACHED = `UAPS_ST_DETACHED;
  localparam ST_IDLE     = `UAPS_ST_IDLE;
  localparam ST_BUFFER   = `UAPS_ST_BUFFER;
  localparam ST_WAIT_SOF = `UAPS_ST_WAIT_SOF;
  localparam ST_PLAY     = `UAPS_ST_PLAY;
  localparam [5:0] PKT   = `UAPS_PKT_SAMPLES;
  localparam [5:0] PKT_LAST = `UAPS_PKT_SAMPLES - 6'h01;
  localparam [10:0] ZRUN = `UAPS_ZERO_RUN;
  localparam BUF_DEPTH   = `UAPS_BUF_DEPTH;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [31:0] init_cnt_q;
  reg  [15:0] buf_l_q [0:BUF_DEPTH-1];
  reg  [15:0] buf_r_q [0:BUF_DEPTH-1];
  reg  [15:0] dac_l_q;
  reg  [15:0] dac_r_q;
  reg         play_n_q;
  reg         sleep_n_q;
  reg         zero_q;
  reg  [5:0]  wr_ptr_q;
  reg  [5:0]  rd_ptr_q;
  reg  [6:0]  fill_q;
  reg  [10:0] zero_cnt_q;
  wire        accepting;
  wire        push;
  wire        pop;
  wire        empty;
  wire        init_done;

  assign empty = (fill_q == 7'h00);
  assign accepting = (state_q == ST_IDLE) || (state_q == ST_BUFFER) ||
                     (state_q == ST_PLAY) || (state_q == ST_WAIT_SOF);
  // buffer holds exactly one packet; sender waits when it is full
  assign sample_ready_out = accepting && (fill_q < {1'b0, PKT}) && (state_q != ST_WAIT_SOF);
  assign push = sample_valid_in && sample_ready_out;
  assign pop  = (state_q == ST_PLAY) && sample_tick_in && !empty;
  assign setup_ready_out = (state_q != ST_INIT) && bus_attached_in;

  // every data and indicator output comes straight from a flip-flop
  assign dac_left_out              = dac_l_q;
  assign dac_right_out             = dac_r_q;
  assign playing_indicator_n_out   = play_n_q;
  assign bus_sleep_indicator_n_out = sleep_n_q;
  assign zero_indicator_out        = zero_q;

  // init counter stops at its end value so it never wraps back into init
  assign init_done = (init_cnt_q >= INIT_CYCLES - 1);

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q    <= ST_INIT;
      init_cnt_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      if (state_q == ST_INIT && !init_done) begin
        init_cnt_q <= init_cnt_q + 32'h00000001;
      end
    end
  end

  // a detach from any running state drops back to detached and flushes the buffer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_INIT: begin
        if (init_done) begin
          state_d = ST_DETACHED;
        end
      end
      ST_DETACHED: begin
        if (bus_attached_in) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!bus_attached_in) begin
          state_d = ST_DETACHED;
        end else if (push) begin
          state_d = ST_BUFFER;
        end
      end
      ST_BUFFER: begin
        // a stream closed before the packet fills still plays what arrived
        if (!bus_attached_in) begin
          state_d = ST_DETACHED;
        end else if (push && fill_q == {1'b0, PKT_LAST}) begin
          state_d = ST_WAIT_SOF;
        end else if (!stream_active_in && !push) begin
          state_d = ST_WAIT_SOF;
        end
      end
      ST_WAIT_SOF: begin
        if (!bus_attached_in) begin
          state_d = ST_DETACHED;
        end else if (sof_in) begin
          state_d = ST_PLAY;
        end
      end
      ST_PLAY: begin
        if (!bus_attached_in) begin
          state_d = ST_DETACHED;
        end else if (!stream_active_in && !sample_valid_in && empty) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_INIT;
      end
    endcase
  end

  // write port: each slot loads only when the write pointer names it
  genvar gi;
  generate
    for (gi = 0; gi < BUF_DEPTH; gi = gi + 1) begin : g_buf
      always @(posedge clk_sys_in) begin
        if (push && wr_ptr_q == gi) begin
          buf_l_q[gi] <= sample_left_in;
          buf_r_q[gi] <= sample_right_in;
        end
      end
    end
  endgenerate

  // pointers wrap at one packet, so only the first packet-depth slots are used
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_q <= 6'h00;
      rd_ptr_q <= 6'h00;
      fill_q   <= 7'h00;
    end else if (state_q == ST_DETACHED || state_q == ST_INIT) begin
      wr_ptr_q <= 6'h00;
      rd_ptr_q <= 6'h00;
      fill_q   <= 7'h00;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PKT_LAST) ? 6'h00 : wr_ptr_q + 6'h01;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PKT_LAST) ? 6'h00 : rd_ptr_q + 6'h01;
      end
      if (push && !pop) begin
        fill_q <= fill_q + 7'h01;
      end else if (pop && !push) begin
        fill_q <= fill_q - 7'h01;
      end
    end
  end

  // an underrun in play holds the last sample rather than jumping to mid-scale
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dac_l_q <= `UAPS_MIDSCALE;
      dac_r_q <= `UAPS_MIDSCALE;
    end else if (pop) begin
      dac_l_q <= buf_l_q[rd_ptr_q];
      dac_r_q <= buf_r_q[rd_ptr_q];
    end else if (state_q != ST_PLAY) begin
      dac_l_q <= `UAPS_MIDSCALE;
      dac_r_q <= `UAPS_MIDSCALE;
    end
  end

  // the zero run counts only samples actually played out
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      zero_cnt_q <= 11'h000;
      zero_q     <= 1'b1;
    end else if (state_q != ST_PLAY) begin
      zero_cnt_q <= 11'h000;
      zero_q     <= 1'b1;
    end else if (pop) begin
      if (buf_l_q[rd_ptr_q] != 16'h0000 || buf_r_q[rd_ptr_q] != 16'h0000) begin
        zero_cnt_q <= 11'h000;
        zero_q     <= 1'b0;
      end else if (zero_cnt_q < ZRUN) begin
        zero_cnt_q <= zero_cnt_q + 11'h001;
        if (zero_cnt_q == ZRUN - 11'h001) begin
          zero_q <= 1'b1;
        end
      end
    end
  end

  // indicators follow the state and the suspend input one clock late
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      play_n_q  <= 1'b1;
      sleep_n_q <= 1'b1;
    end else begin
      play_n_q  <= !(state_q == ST_PLAY);
      sleep_n_q <= !bus_suspend_in;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/uaps_sequencer_asserts.sv */
// port assertions for the playback sequencer
`timescale 1ns/100ps
`default_nettype none
module uaps_sequencer_chk #(
  parameter int INIT_CYCLES = 3500
) (
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        bus_attached_in,
  input wire logic        bus_suspend_in,
  input wire logic        sof_in,
  input wire logic        stream_active_in,
  input wire logic        setup_ready_out,
  input wire logic [15:0] dac_left_out,
  input wire logic        playing_indicator_n_out,
  input wire logic        bus_sleep_indicator_n_out,
  input wire logic        zero_indicator_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire p = playing_indicator_n_out;
  // clock edges seen since reset was released, saturating
  logic [31:0] up_q;
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) up_q <= 32'h0;
    else if (up_q != 32'hffffffff) up_q <= up_q + 32'h1;
  end
  sequence idle3;
    $past(p, 2) && $past(p) && p;
  endsequence
  ready_gate_a: assert property (setup_ready_out |-> up_q >= INIT_CYCLES)
    else $error("ready");
  idle_zero_a: assert property (idle3 |-> zero_indicator_out) else $error("zero");
  idle_mid_a: assert property (idle3 |-> $past(dac_left_out) == 16'h0000) else $error("mid");
  zero_play_a: assert property (!zero_indicator_out |-> !p) else $error("zero idle");
  sof_start_a: assert property ($fell(p) |-> $past(sof_in, 2)) else $error("start");
  stop_drain_a: assert property ($rose(p) |->
    !$past(stream_active_in, 2) || !$past(bus_attached_in, 2)) else $error("stop");
  sleep_set_a: assert property (bus_suspend_in |=> !bus_sleep_indicator_n_out) else $error("s");
  sleep_clr_a: assert property (!bus_suspend_in |=> bus_sleep_indicator_n_out) else $error("w");
  cover property ($fell(p));
  cover property ($rose(p));
  cover property ($fell(zero_indicator_out));
endmodule
bind uaps_sequencer uaps_sequencer_chk #(.INIT_CYCLES(INIT_CYCLES)) chk (.*);
`default_nettype wire

/* File: testbench/uaps_host_model.sv */
// host model: held samples, frame starts every 192 clocks, sample tick every 4
`timescale 1ns/100ps
`default_nettype none
module uaps_host (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        en_in,
  input  wire logic [31:0] w_in,
  output wire logic        vld_out,
  output wire logic [31:0] d_out,
  output wire logic        sof_out,
  output wire logic        tick_out
);
  logic [7:0] c_q;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) c_q <= 8'h00;
    else c_q <= (c_q == 8'hbf) ? 8'h00 : c_q + 8'h01;
  end
  assign vld_out = en_in;
  // released data lines show the inverse of the last word
  assign d_out = en_in ? w_in : ~w_in;
  assign sof_out = c_q == 8'h00;
  assign tick_out = c_q[1:0] == 2'h0;
endmodule
`default_nettype wire

/* File: testbench/uaps_sequencer_test.sv */
// self-checking bench for the playback sequencer
`timescale 1ns/100ps
`default_nettype none
module uaps_sequencer_test;
  logic clk = 1'b0, rst = 1'b1, att = 1'b1, susp = 1'b0, str = 1'b1, en = 1'b0;
  logic zrun = 1'b0, pt = 1'b0, zp = 1'b0, vld, rdy, sof, tick, zo, pn, sr, sn;
  logic [31:0] w = 32'h0, lw = 32'h0, rs = 32'h0000442c, pv = 32'h0, d;
  logic [15:0] l, r;
  logic [31:0] q[$];
  int errors = 0, total_checks = 0, z = 0;
  initial forever #50 clk = ~clk;
  uaps_sequencer #(.INIT_CYCLES(10)) dut (.clk_sys_in(clk), .rst_in(rst), .bus_attached_in(att),
    .bus_suspend_in(susp), .sof_in(sof), .stream_active_in(str), .sample_valid_in(vld),
    .sample_left_in(d[31:16]), .sample_right_in(d[15:0]), .sample_tick_in(tick),
    .setup_ready_out(sr), .sample_ready_out(rdy), .dac_left_out(l), .dac_right_out(r),
    .playing_indicator_n_out(pn), .bus_sleep_indicator_n_out(sn), .zero_indicator_out(zo));
  uaps_host host (.clk_in(clk), .rst_in(rst), .en_in(en), .w_in(w), .vld_out(vld),
    .d_out(d), .sof_out(sof), .tick_out(tick));
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("FAIL t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task give_verdict();
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // note a word only where it will change the outputs
  task send(input int n, input logic zr);
    repeat (n) begin
      w = zr ? 32'h0 : xs();
      en = 1'b1;
      if (w !== lw) q.push_back(w);
      lw = w;
      // ready settles just after an edge and holds until the next one
      while (rdy !== 1'b1) begin
        @(posedge clk);
        #1;
      end
      @(posedge clk);
      #1;
    end
  endtask
  always @(negedge clk) if (!rst) begin
    if ({l, r} !== pv) chk({l, r}, q.size() ? q.pop_front() : 32'h0);
    if ({l, r} !== pv && {l, r} === 32'h0) z = 1;
    else if (pt) z++;
    if (zrun && zo === 1'b1 && zp === 1'b0) chk(32'(z), 32'd1024);
    pt = tick && !pn;
    zp = zo;
    pv = {l, r};
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk);
    #1 chk(32'(sr), 32'h0);
    repeat (4) @(posedge clk);
    #1 chk(32'({sr, zo, pn, sn}), 32'hf);
    chk({l, r}, 32'h0);
    send(100, 1'b0);
    chk(32'({pn, zo}), 32'h0);
    zrun = 1'b1;
    send(1100, 1'b1);
    chk(32'(zo), 32'h1);
    zrun = 1'b0;
    send(60, 1'b0);
    chk(32'(zo), 32'h0);
    str = 1'b0;
    en = 1'b0;
    for (int i = 0; i < 400 && pn !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    repeat (3) @(posedge clk);
    #1 chk(32'(q.size()), 32'h0);
    chk(32'({pn, zo}), 32'h3);
    // a stream closed before one packet is buffered still plays out fully
    str = 1'b1;
    send(20, 1'b0);
    str = 1'b0;
    en = 1'b0;
    repeat (400) @(posedge clk);
    #1 chk(32'(q.size()), 32'h0);
    chk(32'({pn, zo}), 32'h3);
    chk({l, r}, 32'h0);
    susp = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(32'(sn), 32'h0);
    susp = 1'b0;
    att = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(32'({sn, sr}), 32'h2);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
